// ### cwas_ack_tracker.v
`timescale 1ns/1ps
// ************************************************************
// write-ack tracker: counts completed B handshakes, emits acks
// ************************************************************
module cwas_ack_tracker #(
	parameter CNT_W = 4
) (
	// clock and reset
	input  wire             sys_clk,
	input  wire             nrst,
	input  wire             clk_en,
	// completed write response handshake, same clock
	input  wire             bresp_done,
	// acknowledge out
	output reg              wack_ff,
	output reg  [CNT_W-1:0] pend_ff
);
	reg [CNT_W-1:0] nxt_pend;
	reg             nxt_wack;

	// one ack per handshake, never withheld for other traffic; backlog drains one per cycle
	always @* begin
		nxt_wack = (pend_ff != {CNT_W{1'b0}});
		nxt_pend = pend_ff + {{(CNT_W-1){1'b0}}, bresp_done} - {{(CNT_W-1){1'b0}}, nxt_wack};
	end

	// ack goes high the cycle after pend increments at the earliest
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wack_ff <= 1'b0;
			pend_ff <= {CNT_W{1'b0}};
		end else if (clk_en) begin
			wack_ff <= nxt_wack;
			pend_ff <= nxt_pend;
		end
	end
endmodule // cwas_ack_tracker

// ### cwas_host.v
`timescale 1ns/1ps
`include "cwas_map.vh"
module cwas_host #(
	parameter ADDR_W  = 32,
	parameter BUS_B   = 16,
	parameter ALIGN_W = 4,
	parameter CNT_W   = 4
) (
	// clock, reset, enable
	input  wire                   sys_clk,
	input  wire                   nrst,
	input  wire                   clk_en,
	// observed write response handshake
	input  wire                   bvalid,
	input  wire                   bready,
	// write acknowledge from master
	input  wire                   wack,
	// snoop address channel toward master
	output reg                    acvalid_ff,
	input  wire                   acready,
	output reg  [ADDR_W-1:0]      acaddr_ff,
	output reg  [`CWAS_SNP_W-1:0] acsnoop_ff,
	output reg  [`CWAS_PROT_W-1:0] acprot_ff,
	// user request side
	input  wire                   req_valid,
	input  wire [`CWAS_REQ_W-1:0] req_kind,
	input  wire [ADDR_W-1:0]      req_addr,
	input  wire [`CWAS_SNP_W-1:0] req_snoop,
	input  wire [`CWAS_PROT_W-1:0] req_prot,
	output reg                    req_ready_ff,
	output reg                    req_reject_ff,
	output reg                    snoop_done_ff,
	output reg  [CNT_W-1:0]       wack_pend_ff
);
	// ************************************************************
	// input synchronisers for the master's pins
	// ************************************************************
	// each pin gets its own two flops; the handshake is formed only after them
	reg [3:0] meta_ff;
	reg [3:0] sync_ff;
	wire      acready_s = sync_ff[0];
	wire      wack_s    = sync_ff[1];
	wire      bdone_s   = sync_ff[2] & sync_ff[3];

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= 4'h0;
			sync_ff <= 4'h0;
		end else if (clk_en) begin
			meta_ff <= {bready, bvalid, wack, acready};
			sync_ff <= meta_ff;
		end
	end

	// ************************************************************
	// expected acks versus returned acks
	// ************************************************************
	wire [CNT_W-1:0] exp_pend;

	cwas_ack_tracker #(.CNT_W(CNT_W)) u_trk (
		.sys_clk    (sys_clk),
		.nrst       (nrst),
		.clk_en     (clk_en),
		.bresp_done (bdone_s),
		.wack_ff    (),
		.pend_ff    (exp_pend)
	);

	// outstanding writes not yet acked; each one-cycle ack retires one
	reg  [CNT_W-1:0] out_ff;
	wire [CNT_W-1:0] nxt_out = out_ff + {{(CNT_W-1){1'b0}}, bdone_s}
		- {{(CNT_W-1){1'b0}}, wack_s};

	// ************************************************************
	// snoop request qualification
	// ************************************************************
	localparam [ADDR_W-1:0] ALIGN_MASK = {{(ADDR_W-ALIGN_W){1'b1}}, {ALIGN_W{1'b0}}};

	reg snp_ok;
	always @* begin
		case (req_snoop)
			`CWAS_SNP_READ_ONCE, `CWAS_SNP_READ_SHARED, `CWAS_SNP_READ_CLEAN,
			`CWAS_SNP_READ_NSD, `CWAS_SNP_READ_UNIQUE, `CWAS_SNP_CLEAN_SHARED,
			`CWAS_SNP_CLEAN_INVALID, `CWAS_SNP_MAKE_INVALID,
			`CWAS_SNP_DVM_COMPLETE, `CWAS_SNP_DVM_MESSAGE: snp_ok = 1'b1;
			default: snp_ok = 1'b0;
		endcase
	end

	// translated requests: bit0 of req_snoop picks make-invalid vs clean-invalid
	wire [`CWAS_SNP_W-1:0] mapped_snoop = (req_kind == `CWAS_REQ_TRANSLATED) ?
		(req_snoop[0] ? `CWAS_SNP_MAKE_INVALID : `CWAS_SNP_CLEAN_INVALID) : req_snoop;
	wire kind_ok = (req_kind == `CWAS_REQ_SNOOP) ? snp_ok : (req_kind == `CWAS_REQ_TRANSLATED);

	// ************************************************************
	// snoop channel state machine
	// ************************************************************
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_WAIT = 3'h2;
	localparam [2:0] ST_SEND = 3'h4;

	reg [2:0]              st_ff;
	reg [2:0]              nxt_st;
	reg [ADDR_W-1:0]       hold_addr_ff;
	reg [`CWAS_SNP_W-1:0]  hold_snp_ff;
	reg [`CWAS_PROT_W-1:0] hold_prot_ff;

	// conservative: any outstanding unacked write stalls the snoop, not only same address
	wire quiet = (out_ff == {CNT_W{1'b0}}) && !bdone_s;

	// ************************************************************
	// stale ready guard
	// ************************************************************
	// the synchronised ready lags the pin by the sync depth, so a ready
	// left over from the previous snoop could take a new one; ignore it
	// until the pipeline holds only samples taken while this snoop stood
	reg  [1:0] age_ff;
	wire       ac_take = acready_s && (age_ff == `CWAS_SYNC_DEPTH);

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			age_ff <= 2'h0;
		end else if (clk_en) begin
			if (st_ff != ST_SEND) begin
				age_ff <= 2'h0;
			end else if (age_ff != `CWAS_SYNC_DEPTH) begin
				age_ff <= age_ff + 2'h1;
			end
		end
	end

	always @* begin
		case (st_ff)
			ST_IDLE: nxt_st = (req_valid && kind_ok) ? ST_WAIT : ST_IDLE;
			ST_WAIT: nxt_st = quiet ? ST_SEND : ST_WAIT;
			ST_SEND: nxt_st = ac_take ? ST_IDLE : ST_SEND;
			default: nxt_st = ST_IDLE;
		endcase
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_ff         <= ST_IDLE;
			out_ff        <= {CNT_W{1'b0}};
			hold_addr_ff  <= {ADDR_W{1'b0}};
			hold_snp_ff   <= {`CWAS_SNP_W{1'b0}};
			hold_prot_ff  <= {`CWAS_PROT_W{1'b0}};
			acvalid_ff    <= 1'b0;
			acaddr_ff     <= {ADDR_W{1'b0}};
			acsnoop_ff    <= {`CWAS_SNP_W{1'b0}};
			acprot_ff     <= {`CWAS_PROT_W{1'b0}};
			req_ready_ff  <= 1'b0;
			req_reject_ff <= 1'b0;
			snoop_done_ff <= 1'b0;
			wack_pend_ff  <= {CNT_W{1'b0}};
		end else if (clk_en) begin
			st_ff         <= nxt_st;
			out_ff        <= nxt_out;
			wack_pend_ff  <= exp_pend;
			req_ready_ff  <= (nxt_st == ST_IDLE);
			req_reject_ff <= (st_ff == ST_IDLE) && req_valid && !kind_ok;
			snoop_done_ff <= (st_ff == ST_SEND) && ac_take;
			if (st_ff == ST_IDLE && req_valid && kind_ok) begin
				// full-line aligned address; all three prot bits kept as given, bit one as address-space tag
				hold_addr_ff <= req_addr & ALIGN_MASK;
				hold_snp_ff  <= mapped_snoop;
				hold_prot_ff <= req_prot;
			end
			if (st_ff == ST_WAIT && quiet) begin
				acvalid_ff <= 1'b1;
				acaddr_ff  <= hold_addr_ff;
				acsnoop_ff <= hold_snp_ff;
				acprot_ff  <= hold_prot_ff;
			end else if (st_ff == ST_SEND && ac_take) begin
				acvalid_ff <= 1'b0;
			end
		end
	end
endmodule // cwas_host

// ### cwas_host_bench.sv
`timescale 1ns/1ps
module cwas_host_bench;
	logic sys_clk = 0, nrst = 0, clk_en = 1, req_valid = 0, wr_go = 0, prev_v = 0;
	logic [1:0] req_kind = 0;
	logic [31:0] req_addr = 0;
	logic [3:0] req_snoop = 0, dly = 0;
	logic [2:0] req_prot = 0;
	wire bvalid, bready, wack, acready, acvalid_ff, req_ready_ff, req_reject_ff, snoop_done_ff;
	wire [31:0] acaddr_ff;
	wire [3:0] acsnoop_ff, wack_pend_ff;
	wire [2:0] acprot_ff;
	logic [39:0] q[$];
	int n_errors = 0, compares = 0, n_snp = 0, n_done = 0;
	initial forever #50 sys_clk = ~sys_clk;
	cwas_host i_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .bvalid(bvalid), .bready(bready), .wack(wack),
		.acvalid_ff(acvalid_ff), .acready(acready), .acaddr_ff(acaddr_ff), .acsnoop_ff(acsnoop_ff), .acprot_ff(acprot_ff),
		.req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr), .req_snoop(req_snoop), .req_prot(req_prot),
		.req_ready_ff(req_ready_ff), .req_reject_ff(req_reject_ff), .snoop_done_ff(snoop_done_ff),
		.wack_pend_ff(wack_pend_ff));
	cwas_master_model i_mst (.sys_clk(sys_clk), .nrst(nrst), .acvalid_ff(acvalid_ff), .wr_go(wr_go), .dly(dly),
		.bvalid(bvalid), .bready(bready), .wack(wack), .acready(acready));
	task check(input logic [39:0] got);
		logic [39:0] e;
		e = q.pop_front();
		compares++;
		if (got !== e) begin
			n_errors++;
			$display("unexpected at %0t exp %h got %h", $time, e, got);
		end
	endtask
	task wrap_up;
		if (n_errors == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always @(negedge sys_clk) begin
		if (acvalid_ff && !prev_v) check({1'b0, acaddr_ff, acsnoop_ff, acprot_ff});
		if (req_reject_ff) check(40'h80_0000_0000);
		if (acvalid_ff && !prev_v) n_snp++;
		if (snoop_done_ff) n_done++;
		prev_v <= acvalid_ff;
	end
	task req(input logic [1:0] k, input logic [3:0] c, input logic rej);
		logic [31:0] a;
		logic [2:0] p;
		a = $urandom;
		p = $urandom;
		dly = $urandom % 4;
		for (int i = 0; i < 60 && !req_ready_ff; i++) @(negedge sys_clk);
		{req_valid, req_kind, req_snoop, req_addr, req_prot} = {1'b1, k, c, a, p};
		// translated uniques become invalidating snoops; address loses its low bits
		q.push_back(rej ? 40'h80_0000_0000 : {1'b0, a[31:4], 4'h0, k[0] ? (c[0] ? 4'hd : 4'h9) : c, p});
		@(negedge sys_clk);
		req_valid = 0;
		repeat (3) @(negedge sys_clk);
	endtask
	initial begin
		void'($urandom(32'h93464811));
		repeat (3) @(negedge sys_clk);
		nrst = 1;
		@(negedge sys_clk);
		for (int c = 0; c < 16; c++) req(2'h0, c[3:0], !(c inside {0, 1, 2, 3, 7, 8, 9, 13, 14, 15}));
		req(2'h1, 4'h1, 0);
		req(2'h1, 4'h0, 0);
		req(2'h2, 4'h0, 1);
		req(2'h3, 4'h1, 1);
		// a snoop right behind a write must wait for its acknowledge
		for (int w = 0; w < 4; w++) begin
			{wr_go, dly} = {1'b1, 4'h3 + 4'(w * 3)};
			@(negedge sys_clk);
			wr_go = 0;
			// let the write response pass the host's pin synchronisers first
			repeat (2) @(negedge sys_clk);
			req(2'h0, 4'h7, 0);
		end
		repeat (40) @(negedge sys_clk);
		if (q.size() != 0) n_errors++;
		compares++;
		if (n_done != n_snp || wack_pend_ff !== 4'h0) n_errors++;
		wrap_up;
	end
	initial begin
		#2000000;
		n_errors++;
		wrap_up;
	end
endmodule // cwas_host_bench

// ### cwas_host_chk.sv
`timescale 1ns/1ps
module cwas_host_chk #(parameter ADDR_W = 32, parameter CNT_W = 4) (
	input wire sys_clk, nrst, clk_en, req_valid, req_ready_ff, req_reject_ff, acvalid_ff, snoop_done_ff,
	input wire [1:0] req_kind,
	input wire [3:0] req_snoop, acsnoop_ff,
	input wire [ADDR_W-1:0] acaddr_ff,
	input wire [2:0] acprot_ff,
	input wire [CNT_W-1:0] wack_pend_ff
);
	function automatic bit ok(logic [3:0] c);
		return c inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'hd, 4'he, 4'hf};
	endfunction
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_done_on_drop: assert property ($fell(acvalid_ff) |-> snoop_done_ff) else $error("snoop dropped untaken");
	a_fields_hold: assert property (acvalid_ff && $past(acvalid_ff) |-> $stable({acaddr_ff, acsnoop_ff, acprot_ff}))
		else $error("snoop fields moved");
	a_addr_align: assert property (acvalid_ff |-> acaddr_ff[3:0] == 4'h0) else $error("snoop address unaligned");
	a_type_legal: assert property (acvalid_ff |-> ok(acsnoop_ff)) else $error("reserved snoop type");
	a_done_pulse: assert property (snoop_done_ff |=> !snoop_done_ff) else $error("done too long");
	a_reject_pulse: assert property (req_reject_ff |=> !req_reject_ff) else $error("reject too long");
	a_bad_reject: assert property (req_valid && req_ready_ff && clk_en && (req_kind[1] || (!req_kind[0] && !ok(req_snoop)))
		|-> ##[1:2] req_reject_ff) else $error("bad request not rejected");
	a_no_pend: assert property ($rose(acvalid_ff) |-> wack_pend_ff == '0) else $error("snoop with write unacked");
	c_snoop: cover property ($rose(acvalid_ff));
	c_reject: cover property (req_reject_ff);
	c_stall: cover property (req_valid && wack_pend_ff != '0);
endmodule // cwas_host_chk
bind cwas_host cwas_host_chk #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) i_chk (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
	.req_valid(req_valid), .req_ready_ff(req_ready_ff), .req_reject_ff(req_reject_ff), .acvalid_ff(acvalid_ff),
	.snoop_done_ff(snoop_done_ff), .req_kind(req_kind), .req_snoop(req_snoop), .acsnoop_ff(acsnoop_ff),
	.acaddr_ff(acaddr_ff), .acprot_ff(acprot_ff), .wack_pend_ff(wack_pend_ff));

// ### cwas_map.vh
`ifndef CWAS_MAP_VH
`define CWAS_MAP_VH
// snoop type codes
`define CWAS_SNP_READ_ONCE     4'h0
`define CWAS_SNP_READ_SHARED   4'h1
`define CWAS_SNP_READ_CLEAN    4'h2
`define CWAS_SNP_READ_NSD      4'h3
`define CWAS_SNP_READ_UNIQUE   4'h7
`define CWAS_SNP_CLEAN_SHARED  4'h8
`define CWAS_SNP_CLEAN_INVALID 4'h9
`define CWAS_SNP_MAKE_INVALID  4'hd
`define CWAS_SNP_DVM_COMPLETE  4'he
`define CWAS_SNP_DVM_MESSAGE   4'hf
// field widths and positions
`define CWAS_SNP_W             4
`define CWAS_PROT_W            3
`define CWAS_PROT_SECURE_BIT   1
// depth of the pin synchronisers, in cycles
`define CWAS_SYNC_DEPTH        2'h2
// request kinds accepted on the user side
`define CWAS_REQ_W             2
`define CWAS_REQ_SNOOP         2'h0
`define CWAS_REQ_TRANSLATED    2'h1
`endif

// ### cwas_master_model.sv
`timescale 1ns/1ps
module cwas_master_model (
	input  wire       sys_clk, nrst, acvalid_ff, wr_go,
	input  wire [3:0] dly,
	output logic      bvalid, bready, wack, acready
);
	logic [3:0] ac_cnt_ff;
	logic [4:0] wk_cnt_ff;
	// bench drives on the falling edge; sampling it on the rising edge avoids a race
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			{bvalid, bready, wack, acready, ac_cnt_ff, wk_cnt_ff} <= '0;
		end else begin
			{bvalid, bready} <= {2{wr_go}};
			wack <= (wk_cnt_ff == 5'h1);
			wk_cnt_ff <= wr_go ? dly + 5'h2 : wk_cnt_ff - (wk_cnt_ff != 5'h0);
			ac_cnt_ff <= acvalid_ff ? ac_cnt_ff + 4'h1 : 4'h0;
			acready <= acvalid_ff && ac_cnt_ff >= dly;
		end
	end
endmodule // cwas_master_model
